// ===== verilog/gspi_status_defines.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * global status word, fault status and system configuration registers.
 * Assumes a 10 MHz system clock.
 */
`ifndef GSPI_STATUS_DEFINES_SVH
`define GSPI_STATUS_DEFINES_SVH

// ****************************************************************
// Register identifiers on the serial port
// ****************************************************************
`define REG_FAULT_STATUS      8'h00
`define REG_SYSTEM_CONFIG     8'h01

// ****************************************************************
// Top status word bit positions within the 32-bit response
// ****************************************************************
`define TSW_FRAME_ERR         31
`define TSW_DEPLOY_OK         30
`define TSW_DOG_PIN           28
`define TSW_ER_STATE          27
`define TSW_POWER_FLT         26
`define TSW_FAULT             25
`define TSW_CONV_CD           24
`define TSW_CONV_AB           23
`define TSW_WRITE_DENIED      22
`define TSW_BAD_READ          21

// ****************************************************************
// Fault status field positions
// ****************************************************************
`define FS_CHARGE_OT          19
`define FS_BOOST_OT           17
`define FS_OSC_ERR            16
`define FS_RETRY_HI           15
`define FS_RETRY_LO           12
`define FS_OTP_ERR            11
`define FS_DOG2_LOCK          10
`define FS_DOG2_TEST          9
`define FS_DOG2_RST           8
`define FS_DOG1_LOCK          7
`define FS_DOG1_TEST          6
`define FS_DOG1_RST           5
`define FS_DOG_MACH           3
`define FS_SAFE_MACH          2
`define FS_POR                0

// ****************************************************************
// System configuration reset values and writable masks
// ****************************************************************
`define CFG_RESET_VALUE       20'h01808
`define CFG_ANYSTATE_MASK     20'h03006
`define CFG_SAFE_KEEP_MASK    20'h02003
`define CFG_DOG_KEEP_MASK     20'h02002
`define CFG_ALL_MASK          20'h0bfff

// ****************************************************************
// Input-good filter times
// ****************************************************************
`define CLK_MHZ               10
`define FILT_SHORT_NS         1000
`define FILT_LONG_NS          3500
`define FILT_SHORT_CYC        ((`FILT_SHORT_NS * `CLK_MHZ + 999) / 1000)
`define FILT_LONG_CYC         ((`FILT_LONG_NS * `CLK_MHZ + 999) / 1000)
`define FILT_CNT_W            6

`endif

// ===== verilog/gspi_status_pkg.sv
/*
 * Types for the global status and configuration block.
 * Sets its own enum codes and field widths; other numeric values are in the defines header.
 */
package gspi_status_pkg;

   typedef enum logic [2:0] {
      OP_INIT   = 3'b000,
      OP_DIAG   = 3'b001,
      OP_SAFING = 3'b010,
      OP_SCRAP  = 3'b011,
      OP_ARMING = 3'b100
   } oper_state_t;

   typedef struct packed {
      logic       charge_overtemp;
      logic       boost_overtemp;
      logic       osc_error;
      logic       otp_error;
      logic       second_dog_reset;
      logic       dog1_lock;
      logic       dog1_test;
      logic       dog1_reset;
      logic       dog2_lock;
      logic       dog2_test;
      logic [3:0] second_dog_retries;
   } fault_inputs_t;

   typedef struct packed {
      logic       deploy_ok;
      logic       dog_pin;
      logic       er_state;
      logic       power_fault;
      logic       conv_cd;
      logic       conv_ab;
   } summary_inputs_t;

   typedef struct packed {
      logic       auto_off;
      logic       low_power;
      logic       keep_boost_on;
      logic       inhibit_source;
      logic       long_diag;
      logic       short_shift;
      logic [4:0] squib_samples;
      logic [4:0] voltage_samples;
      logic       pad_voltage_mode;
      logic       safing_source;
      logic       high_safing_volt;
      logic       dog1_timeout_disable;
   } config_out_t;

endpackage : gspi_status_pkg

// ===== verilog/sample_decode.sv
/*
 * Decodes the two sample-count fields of the system configuration.
 * Assumes purely combinational use by the register block.
 */
`timescale 1ns/1ps

module sample_decode (
   input  wire logic [1:0] squib_code,
   input  wire logic [1:0] volt_code,
   output logic      [4:0] squib_n,
   output logic      [4:0] volt_n
);

   always_comb begin
      unique case (squib_code)                                         // [RULE17]
         2'b00: squib_n = 5'h08;
         2'b01: squib_n = 5'h10;
         2'b10: squib_n = 5'h04;
         2'b11: squib_n = 5'h02;
      endcase
      unique case (volt_code)                                          // [RULE18]
         2'b00: volt_n = 5'h04;
         2'b01: volt_n = 5'h10;
         2'b10: volt_n = 5'h08;
         2'b11: volt_n = 5'h01;
      endcase
   end

endmodule : sample_decode

// ===== verilog/edge_filter.sv
/*
 * Asymmetric glitch filter for the input-good level.
 * Assumes the input is already synchronised to the clock.
 */
`timescale 1ns/1ps

`include "gspi_status_defines.svh"

module edge_filter (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic sel_long_fall,
   input  wire logic level_in,
   output logic      level_out
);

   logic [`FILT_CNT_W-1:0] cnt_q;
   logic [`FILT_CNT_W-1:0] cnt_d;
   logic [`FILT_CNT_W-1:0] limit;
   logic                   out_q;
   logic                   out_d;

   assign level_out = out_q;

   always_comb begin
      limit = out_q ? (sel_long_fall ? `FILT_CNT_W'(`FILT_LONG_CYC)     // [RULE19]
                                     : `FILT_CNT_W'(`FILT_SHORT_CYC))
                    : `FILT_CNT_W'(`FILT_LONG_CYC);
      out_d = out_q;
      cnt_d = '0;
      if (level_in != out_q) begin
         cnt_d = cnt_q + `FILT_CNT_W'(1);
         if (cnt_d >= limit) begin
            out_d = level_in;
            cnt_d = '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
         out_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

endmodule : edge_filter

// ===== verilog/gspi_status_regs.sv
/*
 * Global status word, fault status register and system configuration
 * register behind the 32-bit serial slave.
 * Assumes the frame decoder supplies one-cycle read/write strobes with
 * register id and data, frame error indications, and internal resets.
 */
// Behaviour
// [RULE1] Top 11 bits of every response carry the status word.
// [RULE2] Frame-error flag sets on bad parity or bit count; clears when read.
// [RULE3] Deploy-success summary is OR of all channel deploy-done bits.
// [RULE4] Energy-reserve bit is one exactly while in reserve state.
// [RULE5] Power-fault summary ORs power state bits 18 to 9.
// [RULE6] Fault summary ORs all fault status bits; resets to one.
// [RULE7] Bits 24 and 23 flag fresh conversions for pairs C/D and A/B.
// [RULE8] Write-denied flag sets when previous write address was forbidden.
// [RULE9] Bad-read flag sets when current read address is unused.
// [RULE10] Each reset sets listed fields; unlisted fields keep their value.
// [RULE11] Over-temperature flags latch; clear on read or power-on reset.
// [RULE12] Oscillator error latches; clears on read or supply power-on reset.
// [RULE13] Retry count field shows second watchdog retries; all resets zero it.
// [RULE14] Checksum error sampled at power-on release; only power-on clears.
// [RULE15] Second watchdog reset latch sets on reset state; clears on read.
// [RULE16] Reset-seen flags set on their reset; clear when read.
// [RULE17] Squib sample code maps 00,01,10,11 to 8,16,4,2.
// [RULE18] Voltage sample code maps 00,01,10,11 to 4,16,8,1.
// [RULE19] Input-good fall filter 1 or 3.5 us; rise fixed 3.5 us.
// [RULE20] Timeout-disable bit suppresses initial watchdog timeout.
// [RULE21] Auto-off switches current source and regulator off after measurement.
// [RULE22] Safing source select: 0 internal, 1 external; resets to one.
// [RULE23] Only four configuration bits writable outside initialization state.
// [RULE24] Unused and zero positions always read zero.
`timescale 1ns/1ps

`include "gspi_status_defines.svh"

module gspi_status_regs (
   input  wire logic                            SYS_CLK,
   input  wire logic                            RST,
   input  wire logic                            POR_RST,
   input  wire logic                            DOG_MACHINE_RESET,
   input  wire logic                            SAFING_MACHINE_RESET,
   input  wire logic                            FRAME_END,
   input  wire logic                            FRAME_BAD,
   input  wire logic                            RD_STB,
   input  wire logic [7:0]                      RD_ID,
   input  wire logic                            RD_UNUSED,
   input  wire logic                            WR_STB,
   input  wire logic [7:0]                      WR_ID,
   input  wire logic                            WR_FORBIDDEN,
   input  wire logic [19:0]                     WR_DATA,
   input  wire gspi_status_pkg::oper_state_t    OPER_STATE,
   input  wire gspi_status_pkg::fault_inputs_t  FAULT_IN,
   input  wire gspi_status_pkg::summary_inputs_t SUM_IN,
   input  wire logic                            OTP_CHECK_FAIL,
   input  wire logic                            INPUT_GOOD_RAW,
   input  wire logic                            MEAS_DONE,
   output logic      [31:0]                     RESP_WORD,
   output gspi_status_pkg::config_out_t         CFG_OUT,
   output logic                                 INPUT_GOOD,
   output logic                                 MEAS_SOURCE_OFF
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [1:0] ig_sync_q;
   logic [1:0] ig_sync_d;
   logic [1:0] dog_sync_q;
   logic [1:0] dog_sync_d;

   always_comb begin
      ig_sync_d  = {ig_sync_q[0], INPUT_GOOD_RAW};
      dog_sync_d = {dog_sync_q[0], SUM_IN.dog_pin};
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ig_sync_q  <= 2'b00;
         dog_sync_q <= 2'b00;
      end else begin
         ig_sync_q  <= ig_sync_d;
         dog_sync_q <= dog_sync_d;
      end
   end

   // ****************************************************************
   // Fault status register
   // ****************************************************************
   logic [19:0] fault_q;
   logic [19:0] fault_d;
   logic        por_prev_q;
   logic        por_prev_d;
   logic        dog_prev_q;
   logic        dog_prev_d;
   logic        safe_prev_q;
   logic        safe_prev_d;
   logic        fault_rd;

   assign fault_rd = RD_STB && (RD_ID == `REG_FAULT_STATUS);

   function automatic logic latch_bit(input logic cur, input logic clr, input logic set);
      latch_bit = set | (cur & ~clr);
   endfunction : latch_bit

   always_comb begin
      fault_d     = fault_q;
      por_prev_d  = POR_RST;
      dog_prev_d  = DOG_MACHINE_RESET;
      safe_prev_d = SAFING_MACHINE_RESET;
      fault_d[`FS_CHARGE_OT] = latch_bit(fault_q[`FS_CHARGE_OT], fault_rd,
         FAULT_IN.charge_overtemp); // [RULE11]
      fault_d[`FS_BOOST_OT] = latch_bit(fault_q[`FS_BOOST_OT], fault_rd,
         FAULT_IN.boost_overtemp); // [RULE11]
      fault_d[`FS_OSC_ERR] = latch_bit(fault_q[`FS_OSC_ERR], fault_rd,
         FAULT_IN.osc_error); // [RULE12]
      fault_d[`FS_RETRY_HI:`FS_RETRY_LO] = FAULT_IN.second_dog_retries; // [RULE13]
      if (por_prev_q && !POR_RST) begin
         fault_d[`FS_OTP_ERR] = OTP_CHECK_FAIL; // [RULE14]
      end
      fault_d[`FS_DOG2_LOCK] = FAULT_IN.dog2_lock;
      fault_d[`FS_DOG2_TEST] = FAULT_IN.dog2_test;
      fault_d[`FS_DOG2_RST] = latch_bit(fault_q[`FS_DOG2_RST], fault_rd,
         FAULT_IN.second_dog_reset); // [RULE15]
      fault_d[`FS_DOG1_LOCK] = FAULT_IN.dog1_lock;
      fault_d[`FS_DOG1_TEST] = FAULT_IN.dog1_test;
      fault_d[`FS_DOG1_RST] = FAULT_IN.dog1_reset;
      fault_d[`FS_DOG_MACH] = latch_bit(fault_q[`FS_DOG_MACH], fault_rd,
         DOG_MACHINE_RESET && !dog_prev_q); // [RULE16]
      fault_d[`FS_SAFE_MACH] = latch_bit(fault_q[`FS_SAFE_MACH], fault_rd,
         SAFING_MACHINE_RESET && !safe_prev_q); // [RULE16]
      fault_d[`FS_POR] = latch_bit(fault_q[`FS_POR], fault_rd, 1'b0);
      fault_d[18] = 1'b0; // [RULE24]
      fault_d[4] = 1'b0;
      fault_d[1] = 1'b0;
      if (SAFING_MACHINE_RESET) begin // [RULE10]
         fault_d[`FS_RETRY_HI:`FS_RETRY_LO] = 4'h0; // [RULE13]
         fault_d[`FS_SAFE_MACH] = 1'b1; // [RULE16]
      end
      if (DOG_MACHINE_RESET) begin // [RULE10]
         fault_d[`FS_RETRY_HI:`FS_RETRY_LO] = 4'h0;
         fault_d[`FS_DOG2_RST] = 1'b0;
         fault_d[`FS_DOG_MACH] = 1'b1; // [RULE16]
         fault_d[`FS_SAFE_MACH] = 1'b1;
      end
      if (POR_RST) begin // [RULE10]
         fault_d = 20'h0;
         fault_d[`FS_DOG_MACH] = 1'b1;
         fault_d[`FS_SAFE_MACH] = 1'b1;
         fault_d[`FS_POR] = 1'b1; // [RULE16]
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         fault_q     <= 20'h0000d;
         por_prev_q  <= 1'b0;
         dog_prev_q  <= 1'b0;
         safe_prev_q <= 1'b0;
      end else begin
         fault_q     <= fault_d;
         por_prev_q  <= por_prev_d;
         dog_prev_q  <= dog_prev_d;
         safe_prev_q <= safe_prev_d;
      end
   end

   // ****************************************************************
   // System configuration register
   // ****************************************************************
   logic [19:0] cfg_q;
   logic [19:0] cfg_d;
   logic [19:0] wr_mask;

   always_comb begin
      cfg_d   = cfg_q;
      wr_mask = (OPER_STATE == gspi_status_pkg::OP_INIT) ? `CFG_ALL_MASK
         : `CFG_ANYSTATE_MASK; // [RULE23]
      if (WR_STB && (WR_ID == `REG_SYSTEM_CONFIG) && !WR_FORBIDDEN) begin
         cfg_d = (cfg_q & ~wr_mask) | (WR_DATA & wr_mask);
      end
      if (SAFING_MACHINE_RESET) begin // [RULE10]
         cfg_d = (cfg_q & `CFG_SAFE_KEEP_MASK)
            | (`CFG_RESET_VALUE & ~`CFG_SAFE_KEEP_MASK); // [RULE22]
      end
      if (DOG_MACHINE_RESET) begin // [RULE20]
         cfg_d = (cfg_q & `CFG_DOG_KEEP_MASK)
               | (`CFG_RESET_VALUE & ~`CFG_DOG_KEEP_MASK);
      end
      if (POR_RST) begin
         cfg_d = `CFG_RESET_VALUE;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cfg_q <= `CFG_RESET_VALUE;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // ****************************************************************
   // Configuration outputs
   // ****************************************************************
   logic [4:0]                    sq_n;
   logic [4:0]                    vm_n;
   logic                          ig_filt;
   gspi_status_pkg::config_out_t  cfg_out_q;
   gspi_status_pkg::config_out_t  cfg_out_d;
   logic                          ig_q;
   logic                          src_off_q;
   logic                          src_off_d;

   sample_decode u_decode (
      .squib_code (cfg_q[8:7]),
      .volt_code  (cfg_q[6:5]),
      .squib_n    (sq_n),
      .volt_n     (vm_n)
   );

   edge_filter u_filter (
      .clk           (SYS_CLK),
      .rst           (RST),
      .sel_long_fall (cfg_q[1]), // [RULE19]
      .level_in      (ig_sync_q[1]),
      .level_out     (ig_filt)
   );

   always_comb begin
      cfg_out_d.auto_off = cfg_q[15];
      cfg_out_d.low_power = cfg_q[13];
      cfg_out_d.keep_boost_on = cfg_q[12];
      cfg_out_d.inhibit_source = cfg_q[11];
      cfg_out_d.long_diag = cfg_q[10];
      cfg_out_d.short_shift = cfg_q[9];
      cfg_out_d.squib_samples = sq_n;
      cfg_out_d.voltage_samples = vm_n;
      cfg_out_d.pad_voltage_mode = cfg_q[4];
      cfg_out_d.safing_source = cfg_q[3]; // [RULE22]
      cfg_out_d.high_safing_volt = cfg_q[2];
      cfg_out_d.dog1_timeout_disable = cfg_q[0]; // [RULE20]
      src_off_d = cfg_q[15] && MEAS_DONE; // [RULE21]
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cfg_out_q <= '0;
         ig_q      <= 1'b0;
         src_off_q <= 1'b0;
      end else begin
         cfg_out_q <= cfg_out_d;
         ig_q      <= ig_filt;
         src_off_q <= src_off_d;
      end
   end

   assign CFG_OUT         = cfg_out_q;
   assign INPUT_GOOD      = ig_q;
   assign MEAS_SOURCE_OFF = src_off_q;

   // ****************************************************************
   // Status word flags and response
   // ****************************************************************
   logic        frame_err_q;
   logic        frame_err_d;
   logic        wr_denied_q;
   logic        wr_denied_d;
   logic [31:0] resp_q;
   logic [31:0] resp_d;
   logic        any_reset;

   assign any_reset = POR_RST || DOG_MACHINE_RESET || SAFING_MACHINE_RESET;

   always_comb begin
      frame_err_d = latch_bit(frame_err_q, RD_STB, FRAME_END && FRAME_BAD); // [RULE2]
      wr_denied_d = latch_bit(wr_denied_q, RD_STB, WR_STB && WR_FORBIDDEN); // [RULE8]
      if (any_reset) begin
         frame_err_d = 1'b0;
         wr_denied_d = 1'b0;
      end
      resp_d = resp_q;
      if (RD_STB) begin
         resp_d = 32'h0; // [RULE24]
         resp_d[`TSW_FRAME_ERR] = frame_err_q; // [RULE1]
         resp_d[`TSW_DEPLOY_OK] = SUM_IN.deploy_ok; // [RULE3]
         resp_d[`TSW_DOG_PIN] = dog_sync_q[1];
         resp_d[`TSW_ER_STATE] = SUM_IN.er_state; // [RULE4]
         resp_d[`TSW_POWER_FLT] = SUM_IN.power_fault; // [RULE5]
         resp_d[`TSW_FAULT] = |fault_q; // [RULE6]
         resp_d[`TSW_CONV_CD] = SUM_IN.conv_cd; // [RULE7]
         resp_d[`TSW_CONV_AB] = SUM_IN.conv_ab; // [RULE7]
         resp_d[`TSW_WRITE_DENIED] = wr_denied_q; // [RULE8]
         resp_d[`TSW_BAD_READ] = RD_UNUSED; // [RULE9]
         if (!RD_UNUSED && RD_ID == `REG_FAULT_STATUS) begin
            resp_d[19:0] = fault_q;
         end else if (!RD_UNUSED && RD_ID == `REG_SYSTEM_CONFIG) begin
            resp_d[19:0] = cfg_q;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         frame_err_q <= 1'b0;
         wr_denied_q <= 1'b0;
         resp_q      <= 32'h02000000; // [RULE6]
      end else begin
         frame_err_q <= frame_err_d;
         wr_denied_q <= wr_denied_d;
         resp_q      <= resp_d;
      end
   end

   assign RESP_WORD = resp_q;

endmodule : gspi_status_regs

// ===== sim/gspi_status_checker.sv
/* Port assertions of the status and configuration block.
   Assumes one clock and the synchronous reset RST. */
`timescale 1ns/1ps

`include "gspi_status_defines.svh"

module gspi_status_checker (
   input wire logic                             SYS_CLK,
   input wire logic                             RST,
   input wire logic                             FRAME_END,
   input wire logic                             FRAME_BAD,
   input wire logic                             RD_STB,
   input wire logic [7:0]                       RD_ID,
   input wire logic                             RD_UNUSED,
   input wire logic                             WR_STB,
   input wire logic                             WR_FORBIDDEN,
   input wire gspi_status_pkg::fault_inputs_t   FAULT_IN,
   input wire gspi_status_pkg::summary_inputs_t SUM_IN,
   input wire logic                             MEAS_DONE,
   input wire logic [31:0]                      RESP_WORD,
   input wire gspi_status_pkg::config_out_t     CFG_OUT,
   input wire logic                             MEAS_SOURCE_OFF
);
   gspi_status_pkg::summary_inputs_t sum_q;

   always_ff @(posedge SYS_CLK) begin
      sum_q <= SUM_IN;
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   property p_rst_value; $fell(RST) |-> RESP_WORD == 32'h02000000; endproperty
   a_rst_value: assert property (p_rst_value) else $error("reset response");
   property p_hold; !RD_STB |=> $stable(RESP_WORD); endproperty
   a_hold: assert property (p_hold) else $error("response moved");
   property p_bad_read; RD_STB |=> RESP_WORD[21] == $past(RD_UNUSED)
      && (!RESP_WORD[21] || RESP_WORD[19:0] == 20'h0); endproperty
   a_bad_read: assert property (p_bad_read) else $error("bad read flag");
   property p_summary; RD_STB && $stable(SUM_IN) |=> {RESP_WORD[30:26], RESP_WORD[24:23]}
      == {sum_q.deploy_ok, 1'b0, RESP_WORD[28], sum_q.er_state, sum_q.power_fault,
          sum_q.conv_cd, sum_q.conv_ab}; endproperty
   a_summary: assert property (p_summary) else $error("sum");
   property p_fault_sum; RD_STB && RD_ID == `REG_FAULT_STATUS && !RD_UNUSED |=>
      RESP_WORD[25] == (|RESP_WORD[19:0]) && RESP_WORD[18] == 1'b0 && RESP_WORD[4] == 1'b0
      && RESP_WORD[1] == 1'b0; endproperty
   a_fault_sum: assert property (p_fault_sum) else $error("fault summary");
   property p_cfg_zero; RD_STB && RD_ID == `REG_SYSTEM_CONFIG && !RD_UNUSED |=>
      RESP_WORD[19:16] == 4'h0 && RESP_WORD[14] == 1'b0; endproperty
   a_cfg_zero: assert property (p_cfg_zero) else $error("config zero bits");
   property p_frame_err; FRAME_END && FRAME_BAD ##1 !RD_STB ##1 RD_STB |=> RESP_WORD[31];
   endproperty
   a_frame_err: assert property (p_frame_err) else $error("frame error flag");
   property p_denied; WR_STB && WR_FORBIDDEN ##1 !RD_STB ##1 RD_STB |=> RESP_WORD[22];
   endproperty
   a_denied: assert property (p_denied) else $error("write denied flag");
   property p_rd_clear; (RD_STB && RD_ID == `REG_FAULT_STATUS && !RD_UNUSED && FAULT_IN == '0)
      ##1 (!RD_STB && FAULT_IN == '0) ##1 (RD_STB && RD_ID == `REG_FAULT_STATUS && !RD_UNUSED)
      |=> RESP_WORD[19:16] == 4'h0 && RESP_WORD[8] == 1'b0; endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("latch");
   property p_auto_off; MEAS_DONE && CFG_OUT.auto_off |=> MEAS_SOURCE_OFF; endproperty
   a_auto_off: assert property (p_auto_off) else $error("no auto off");

   c_bad_frame: cover property (FRAME_END && FRAME_BAD);
   c_denied: cover property (WR_STB && WR_FORBIDDEN);
   c_auto_off: cover property (MEAS_SOURCE_OFF);
endmodule : gspi_status_checker

bind gspi_status_regs gspi_status_checker gspi_status_checker_i (.*);

// ===== sim/gspi_host_model.sv
/* Frame-level host: read, write and frame-end strobes.
   Assumes calls begin just after a rising clock edge. */
`timescale 1ns/1ps

`include "gspi_status_defines.svh"

module gspi_host_model (
   input  wire logic        clk,
   output logic             rd_stb,
   output logic [7:0]       rd_id,
   output logic             rd_unused,
   output logic             wr_stb,
   output logic             wr_forbidden,
   output logic [19:0]      wr_data,
   output logic             frame_end,
   output logic             frame_bad
);
   initial {rd_stb, rd_id, rd_unused, wr_stb, wr_forbidden, wr_data, frame_end, frame_bad} = '0;

   // Strobe over one edge, then one idle edge
   task automatic fin();
      @(posedge clk) #1 {rd_stb, wr_stb, frame_end} = 3'h0;
      @(posedge clk) #1;
   endtask : fin

   task automatic rd(input logic [7:0] id);
      rd_id = id;
      rd_unused = id > `REG_SYSTEM_CONFIG;
      rd_stb = 1'b1;
      fin();
   endtask : rd

   // Phase check result comes with the write
   task automatic wr(input logic [19:0] d, input logic forbid);
      wr_data = d;
      wr_forbidden = forbid;
      wr_stb = 1'b1;
      fin();
   endtask : wr

   task automatic fend(input logic bad);
      frame_bad = bad;
      frame_end = 1'b1;
      fin();
   endtask : fend
endmodule : gspi_host_model

// ===== sim/tb.sv
/* Self-checking bench of the status and configuration block.
   Assumes the host model drives the frame strobes. */
`timescale 1ns/1ps

module tb;
   logic        SYS_CLK = 1'b0;
   logic        RST = 1'b1;
   logic [3:0]  ev = 4'h0;
   logic        POR_RST, DOG_MACHINE_RESET, SAFING_MACHINE_RESET, MEAS_DONE;
   logic        FRAME_END, FRAME_BAD, RD_STB, RD_UNUSED, WR_STB, WR_FORBIDDEN;
   logic [7:0]  RD_ID;
   logic [7:0]  WR_ID = 8'h01;
   logic [19:0] WR_DATA;
   logic [31:0] RESP_WORD;
   logic        OTP_CHECK_FAIL = 1'b0;
   logic        INPUT_GOOD_RAW = 1'b0;
   logic        INPUT_GOOD, MEAS_SOURCE_OFF;
   gspi_status_pkg::oper_state_t     OPER_STATE = gspi_status_pkg::OP_INIT;
   gspi_status_pkg::fault_inputs_t   FAULT_IN = '0;
   gspi_status_pkg::summary_inputs_t SUM_IN = '0;
   gspi_status_pkg::config_out_t     CFG_OUT;
   logic [4:0]  sq [4] = '{5'h08, 5'h10, 5'h04, 5'h02};
   logic [4:0]  vn [4] = '{5'h04, 5'h10, 5'h08, 5'h01};
   int          num_errors = 0;
   int          samples_checked = 0;

   assign {MEAS_DONE, SAFING_MACHINE_RESET, DOG_MACHINE_RESET, POR_RST} = ev;
   always #50 SYS_CLK = ~SYS_CLK;

   gspi_status_regs gspi_status_regs_i (.SYS_CLK, .RST, .POR_RST, .DOG_MACHINE_RESET,
      .SAFING_MACHINE_RESET, .FRAME_END, .FRAME_BAD, .RD_STB, .RD_ID, .RD_UNUSED, .WR_STB,
      .WR_ID, .WR_FORBIDDEN, .WR_DATA, .OPER_STATE, .FAULT_IN, .SUM_IN, .OTP_CHECK_FAIL,
      .INPUT_GOOD_RAW, .MEAS_DONE, .RESP_WORD, .CFG_OUT, .INPUT_GOOD, .MEAS_SOURCE_OFF);
   gspi_host_model gspi_host_model_i (.clk(SYS_CLK), .rd_stb(RD_STB), .rd_id(RD_ID),
      .rd_unused(RD_UNUSED), .wr_stb(WR_STB), .wr_forbidden(WR_FORBIDDEN), .wr_data(WR_DATA),
      .frame_end(FRAME_END), .frame_bad(FRAME_BAD));

   task automatic wrap_up();
      $display("errors=%0d checks=%0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge SYS_CLK);
      #1;
   endtask : tick

   task automatic rdc(input logic [7:0] id, input logic [31:0] exp);
      gspi_host_model_i.rd(id);
      chk(RESP_WORD, exp);
   endtask : rdc

   task automatic wr(input logic [19:0] d);
      gspi_host_model_i.wr(d, 1'b0);
   endtask : wr

   task automatic pulse(input logic [3:0] m, input logic [4:0] f);
      ev = m;
      FAULT_IN[13:9] = f;
      tick(1);
      ev = 4'h0;
      FAULT_IN[13:9] = 5'h00;
      tick(1);
   endtask : pulse

   initial begin
      #1000000;
      num_errors++;
      wrap_up();
   end

   initial begin
      tick(16);
      RST = 1'b0;
      chk(RESP_WORD, 32'h02000000);
      INPUT_GOOD_RAW = 1'b1;
      tick(25);
      chk({31'h0, INPUT_GOOD}, 32'h0);
      tick(20);
      chk({31'h0, INPUT_GOOD}, 32'h1);
      INPUT_GOOD_RAW = 1'b0;
      tick(5);
      chk({31'h0, INPUT_GOOD}, 32'h1);
      tick(15);
      chk({31'h0, INPUT_GOOD}, 32'h0);
      rdc(8'h00, 32'h0200000d);
      rdc(8'h00, 32'h00000000);
      rdc(8'h01, 32'h00001808);
      for (int c = 0; c < 4; c++) begin
         wr(20'(c * 160));
         tick(2);
         chk({22'h0, CFG_OUT[13:4]}, {22'h0, sq[c], vn[c]});
      end
      wr(20'h08000);
      tick(2);
      ev = 4'h8;
      tick(1);
      chk({31'h0, MEAS_SOURCE_OFF}, 32'h1);
      ev = 4'h0;
      tick(1);
      wr(20'hfffff);
      rdc(8'h01, 32'h0000bfff);
      OPER_STATE = gspi_status_pkg::OP_DIAG;
      wr(20'h00000);
      rdc(8'h01, 32'h00008ff9);
      gspi_host_model_i.wr(20'h00000, 1'b1);
      rdc(8'h01, 32'h00408ff9);
      rdc(8'h01, 32'h00008ff9);
      gspi_host_model_i.fend(1'b1);
      rdc(8'h01, 32'h80008ff9);
      gspi_host_model_i.fend(1'b0);
      rdc(8'h01, 32'h00008ff9);
      rdc(8'h7f, 32'h00200000);
      for (int i = 0; i < 2; i++) begin
         SUM_IN = gspi_status_pkg::summary_inputs_t'(i ? 6'h15 : 6'h2a);
         tick(4);
         rdc(8'h01, (i ? 32'h14800000 : 32'h49000000) | 32'h8ff9);
      end
      SUM_IN = '0;
      FAULT_IN.second_dog_retries = 4'ha;
      tick(3);
      pulse(4'h0, 5'h1d);
      rdc(8'h00, 32'h020ba100);
      rdc(8'h00, 32'h0200a000);
      FAULT_IN = '0;
      wr(20'h02002);
      pulse(4'h2, 5'h00);
      rdc(8'h00, 32'h0200000c);
      rdc(8'h01, 32'h0000380a);
      OPER_STATE = gspi_status_pkg::OP_INIT;
      wr(20'h00001);
      pulse(4'h4, 5'h00);
      rdc(8'h00, 32'h02000004);
      rdc(8'h01, 32'h00001809);
      OTP_CHECK_FAIL = 1'b1;
      pulse(4'h1, 5'h00);
      OTP_CHECK_FAIL = 1'b0;
      rdc(8'h00, 32'h0200080d);
      rdc(8'h00, 32'h02000800);
      rdc(8'h01, 32'h02001808);
      wrap_up();
   end
endmodule : tb
